// [core/aoc_cfg.svh]
// Offsets, field positions, reset values and limits of the output
// configuration bank. Assumes inclusion by its bare name.
// Functional notes
// R1: Each channel holds an eight-bit signed offset trim, reset to zero.
// R2: Output mode bit 0 selects offset binary or twos complement for all channels, bit 2 inverts one channel, reset 0x01.
// R3: Output mode bit 6 selects standard LVDS swing or the reduced-range link for all channels.
// R4: The two-bit termination field gives none for 00, 200 ohms for 01 and 100 ohms for 10 and 11.
// R5: Output adjust bit 0 selects single or double drive strength, reset 0x00.
// R6: The output phase low nibble holds the output clock phase code 0 to 11, reset 0x03.
// R7: Output phase bits 6 to 4 pick which clock divider phase drives the output clock.
// R8: The divider phase choice moves only the output clock and never the sample strobe.
// R9: The reference field maps codes 0 to 4 onto the five input spans, reset 0x04.
// R10: The host picks with the channel index which channels a per-channel write reaches.
// R11: Open bits read zero and ignore writes, and reserved field codes are not taken.
`ifndef AOC_CFG_SVH
`define AOC_CFG_SVH
// ********************************************************************
// Register offsets
// ********************************************************************
`define AOC_OFS_TRIM 8'h10
`define AOC_OFS_FMT 8'h14
`define AOC_OFS_DRV 8'h15
`define AOC_OFS_PHASE 8'h16
`define AOC_OFS_REF 8'h18
// ********************************************************************
// Reset values
// ********************************************************************
`define AOC_RST_TRIM 8'h00
`define AOC_RST_FMT 8'h01
`define AOC_RST_DRV 8'h00
`define AOC_RST_PHASE 8'h03
`define AOC_RST_REF 8'h04
// ********************************************************************
// Field positions and limits
// ********************************************************************
`define AOC_FMT_TWOS_BIT 0
`define AOC_FMT_INV_BIT 2
`define AOC_FMT_LVDS_BIT 6
`define AOC_DRV_STR_BIT 0
`define AOC_DRV_TERM_LSB 4
`define AOC_DRV_TERM_MSB 5
`define AOC_PH_OUT_LSB 0
`define AOC_PH_OUT_MSB 3
`define AOC_PH_IN_LSB 4
`define AOC_PH_IN_MSB 6
`define AOC_REF_LSB 0
`define AOC_REF_MSB 2
`define AOC_PH_OUT_MAX 4'hB
`define AOC_REF_MAX 3'h4
`define AOC_SMP_MAX 12'hFFF
`endif

// [core/aoc_chan_if.sv]
// Per-channel settings and sample path between the bank and one lane.
// Assumes both ends share clk.
`timescale 1ns/1ps
interface aoc_chan_if;
	logic [7:0] trim;
	logic invert;
	logic twos;
	aoc_pkg::aoc_smp_t smp_in;
	logic smp_valid;
	aoc_pkg::aoc_smp_t dat_out;
	logic dat_valid;
	modport bank (output trim, invert, twos, smp_in, smp_valid,
		input dat_out, dat_valid);
	modport lane (input trim, invert, twos, smp_in, smp_valid,
		output dat_out, dat_valid);
endinterface

// [core/aoc_chan_lane.sv]
// One channel lane: offset trim, format and inversion of a sample.
// Assumes offset-binary samples arriving synchronous to clk.
`timescale 1ns/1ps
`include "aoc_cfg.svh"
module aoc_chan_lane (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	aoc_chan_if.lane ch
);
	logic signed [13:0] sum;
	aoc_pkg::aoc_smp_t sat, fmt, dat_r;
	logic vld_r;
	// Trim added in signed arithmetic, clamped to the code range
	assign sum = $signed({2'b00, ch.smp_in}) +
		$signed({{6{ch.trim[7]}}, ch.trim}); // R1
	assign sat = sum[13] ? 12'h000 :
		(sum[12] ? `AOC_SMP_MAX : sum[11:0]);
	assign fmt = ch.twos ? {~sat[11], sat[10:0]} : sat; // R2
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			dat_r <= 12'h000;
			vld_r <= 1'b0;
		end else if (ce) begin
			vld_r <= ch.smp_valid;
			if (ch.smp_valid) begin
				dat_r <= ch.invert ? ~fmt : fmt; // R2
			end
		end
	end
	assign ch.dat_out = dat_r;
	assign ch.dat_valid = vld_r;
endmodule

// [core/aoc_clk_phase.sv]
// Clock divider phase picker: sample strobe and output clock strobe.
// Assumes the divide ratio is held steady by its own register.
`timescale 1ns/1ps
module aoc_clk_phase (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic [2:0] div_ratio,
	input wire logic [2:0] in_phase,
	output logic sample_strobe,
	output logic out_clk_strobe
);
	logic [2:0] cnt_r, cnt_nxt, sel;
	logic smp_r, oclk_r;
	assign cnt_nxt = (cnt_r >= div_ratio) ? 3'h0 : cnt_r + 3'h1;
	// Phase beyond the ratio sticks to the last divider phase
	assign sel = (in_phase > div_ratio) ? div_ratio : in_phase; // R7
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_r <= 3'h0;
			smp_r <= 1'b0;
			oclk_r <= 1'b0;
		end else if (ce) begin
			cnt_r <= cnt_nxt;
			smp_r <= (cnt_nxt == 3'h0); // R8
			oclk_r <= (cnt_nxt == sel); // R7
		end
	end
	assign sample_strobe = smp_r;
	assign out_clk_strobe = oclk_r;
endmodule

// [core/aoc_pkg.sv]
// Types shared by the output configuration bank.
// Assumes nothing of its surroundings.
package aoc_pkg;
	typedef enum logic [1:0] {
		AOC_TERM_NONE = 2'h0,
		AOC_TERM_200 = 2'h1,
		AOC_TERM_100 = 2'h2
	} aoc_term_t;
	typedef enum logic [2:0] {
		AOC_SPAN_1V00 = 3'h0,
		AOC_SPAN_1V14 = 3'h1,
		AOC_SPAN_1V33 = 3'h2,
		AOC_SPAN_1V60 = 3'h3,
		AOC_SPAN_2V00 = 3'h4
	} aoc_span_t;
	typedef logic [11:0] aoc_smp_t;
endpackage

// [core/aoc_top.sv]
// Output configuration bank of a dual converter back end.
// Assumes a byte register port fed by the serial port front end and a
// channel index driven from the device index register outside.
`timescale 1ns/1ps
`include "aoc_cfg.svh"
module aoc_top (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	input wire logic [1:0] chan_index,
	input wire logic [2:0] clk_div_ratio,
	input wire logic smp_valid,
	input wire logic [11:0] smp_a_in,
	input wire logic [11:0] smp_b_in,
	output logic [11:0] dat_a_out,
	output logic [11:0] dat_b_out,
	output logic dat_valid,
	output logic lvds_reduced,
	output aoc_pkg::aoc_term_t term_sel,
	output logic drive_double,
	output logic [3:0] out_clk_phase,
	output logic [2:0] in_clk_phase,
	output aoc_pkg::aoc_span_t ref_span,
	output logic sample_strobe,
	output logic out_clk_strobe
);
	localparam int NCH = 2;
	// Whole reset bytes, so each field resets from its own bit positions
	localparam logic [7:0] RST_TRIM = `AOC_RST_TRIM;
	localparam logic [7:0] RST_FMT = `AOC_RST_FMT;
	localparam logic [7:0] RST_DRV = `AOC_RST_DRV;
	localparam logic [7:0] RST_PHASE = `AOC_RST_PHASE;
	localparam logic [7:0] RST_REF = `AOC_RST_REF;

	// ****************************************************************
	// Address decode
	// ****************************************************************
	function automatic logic aoc_hit(input logic [7:0] a,
		input logic [7:0] ofs);
		aoc_hit = (a == ofs);
	endfunction

	logic hit_trim, hit_fmt, hit_drv, hit_phase, hit_ref;
	logic wr_fmt, wr_drv, wr_phase, wr_ref;
	assign hit_trim = aoc_hit(reg_addr, `AOC_OFS_TRIM);
	assign hit_fmt = aoc_hit(reg_addr, `AOC_OFS_FMT);
	assign hit_drv = aoc_hit(reg_addr, `AOC_OFS_DRV);
	assign hit_phase = aoc_hit(reg_addr, `AOC_OFS_PHASE);
	assign hit_ref = aoc_hit(reg_addr, `AOC_OFS_REF);
	assign wr_fmt = reg_wr & hit_fmt;
	assign wr_drv = reg_wr & hit_drv;
	assign wr_phase = reg_wr & hit_phase;
	assign wr_ref = reg_wr & hit_ref;

	// ****************************************************************
	// Global settings
	// ****************************************************************
	logic twos_r, lvds_r, drv_r;
	logic [1:0] term_r;
	logic [3:0] oph_r, oph_nxt;
	logic [2:0] iph_r;
	logic [2:0] ref_r, ref_nxt;
	logic [3:0] oph_wr;
	logic [2:0] ref_wr;

	assign oph_wr = reg_wdata[`AOC_PH_OUT_MSB:`AOC_PH_OUT_LSB];
	assign ref_wr = reg_wdata[`AOC_REF_MSB:`AOC_REF_LSB];
	// Reserved codes leave the field as it was
	assign oph_nxt = (oph_wr > `AOC_PH_OUT_MAX) ? oph_r : oph_wr; // R6 R11
	assign ref_nxt = (ref_wr > `AOC_REF_MAX) ? ref_r : ref_wr; // R9 R11

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			twos_r <= RST_FMT[`AOC_FMT_TWOS_BIT];
			lvds_r <= RST_FMT[`AOC_FMT_LVDS_BIT];
		end else if (ce && wr_fmt) begin
			twos_r <= reg_wdata[`AOC_FMT_TWOS_BIT]; // R2
			lvds_r <= reg_wdata[`AOC_FMT_LVDS_BIT]; // R3
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			drv_r <= RST_DRV[`AOC_DRV_STR_BIT];
			term_r <= RST_DRV[`AOC_DRV_TERM_MSB:`AOC_DRV_TERM_LSB];
		end else if (ce && wr_drv) begin
			drv_r <= reg_wdata[`AOC_DRV_STR_BIT]; // R5
			term_r <= reg_wdata[`AOC_DRV_TERM_MSB:`AOC_DRV_TERM_LSB]; // R4
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			oph_r <= RST_PHASE[`AOC_PH_OUT_MSB:`AOC_PH_OUT_LSB];
			iph_r <= RST_PHASE[`AOC_PH_IN_MSB:`AOC_PH_IN_LSB];
		end else if (ce && wr_phase) begin
			oph_r <= oph_nxt; // R6
			iph_r <= reg_wdata[`AOC_PH_IN_MSB:`AOC_PH_IN_LSB]; // R7
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ref_r <= RST_REF[`AOC_REF_MSB:`AOC_REF_LSB];
		end else if (ce && wr_ref) begin
			ref_r <= ref_nxt; // R9
		end
	end

	// ****************************************************************
	// Per-channel settings and lanes
	// ****************************************************************
	logic [7:0] trim_r [NCH];
	logic inv_r [NCH];
	aoc_pkg::aoc_smp_t smp_in [NCH];
	aoc_pkg::aoc_smp_t dat_out [NCH];
	logic dat_vld [NCH];

	assign smp_in[0] = smp_a_in;
	assign smp_in[1] = smp_b_in;

	genvar gi;
	generate
		for (gi = 0; gi < NCH; gi++) begin : g_ch
			logic wr_trim_i, wr_inv_i;
			aoc_chan_if cif ();
			// Channel index gates the per-channel writes
			assign wr_trim_i = reg_wr & hit_trim & chan_index[gi]; // R10
			assign wr_inv_i = wr_fmt & chan_index[gi]; // R10
			always_ff @(posedge clk or posedge sys_rst) begin
				if (sys_rst) begin
					trim_r[gi] <= RST_TRIM;
					inv_r[gi] <= RST_FMT[`AOC_FMT_INV_BIT];
				end else if (ce) begin
					if (wr_trim_i) begin
						trim_r[gi] <= reg_wdata; // R1
					end
					if (wr_inv_i) begin
						inv_r[gi] <= reg_wdata[`AOC_FMT_INV_BIT]; // R2
					end
				end
			end
			assign cif.trim = trim_r[gi];
			assign cif.invert = inv_r[gi];
			assign cif.twos = twos_r;
			assign cif.smp_in = smp_in[gi];
			assign cif.smp_valid = smp_valid;
			assign dat_out[gi] = cif.dat_out;
			assign dat_vld[gi] = cif.dat_valid;
			aoc_chan_lane u_lane (
				.clk(clk),
				.sys_rst(sys_rst),
				.ce(ce),
				.ch(cif.lane)
			);
		end
	endgenerate

	assign dat_a_out = dat_out[0];
	assign dat_b_out = dat_out[1];
	assign dat_valid = dat_vld[0];

	// ****************************************************************
	// Clock phase selection
	// ****************************************************************
	aoc_clk_phase u_phase (
		.clk(clk),
		.sys_rst(sys_rst),
		.ce(ce),
		.div_ratio(clk_div_ratio),
		.in_phase(iph_r),
		.sample_strobe(sample_strobe),
		.out_clk_strobe(out_clk_strobe)
	);

	// ****************************************************************
	// Decoded settings
	// ****************************************************************
	logic [1:0] term_dec;
	// Both upper termination codes give the same 100 ohm setting
	assign term_dec = (term_r == 2'h0) ? aoc_pkg::AOC_TERM_NONE :
		((term_r == 2'h1) ? aoc_pkg::AOC_TERM_200 :
		aoc_pkg::AOC_TERM_100); // R4

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			term_sel <= aoc_pkg::AOC_TERM_NONE;
		end else if (ce) begin
			term_sel <= aoc_pkg::aoc_term_t'(term_dec);
		end
	end

	assign lvds_reduced = lvds_r;
	assign drive_double = drv_r;
	assign out_clk_phase = oph_r;
	assign in_clk_phase = iph_r;
	assign ref_span = aoc_pkg::aoc_span_t'(ref_r);

	// ****************************************************************
	// Read back
	// ****************************************************************
	logic rsel;
	logic [7:0] rd_trim, rd_fmt, rd_drv, rd_phase, rd_ref, rd_mux;
	// Lowest selected channel answers a per-channel read
	assign rsel = ~chan_index[0] & chan_index[1];
	assign rd_trim = rsel ? trim_r[1] : trim_r[0];
	// Open positions read zero
	assign rd_fmt = {1'b0, lvds_r, 3'h0, (rsel ? inv_r[1] : inv_r[0]),
		1'b0, twos_r}; // R11
	assign rd_drv = {2'h0, term_r, 3'h0, drv_r}; // R11
	assign rd_phase = {1'b0, iph_r, oph_r}; // R11
	assign rd_ref = {5'h00, ref_r}; // R11
	assign rd_mux = hit_trim ? rd_trim :
		hit_fmt ? rd_fmt :
		hit_drv ? rd_drv :
		hit_phase ? rd_phase :
		hit_ref ? rd_ref : 8'h00;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			reg_rdata <= 8'h00;
			reg_rvalid <= 1'b0;
		end else if (ce) begin
			reg_rvalid <= reg_rd;
			if (reg_rd) begin
				reg_rdata <= rd_mux;
			end
		end
	end
endmodule

// [test/aoc_checker.sv]
// Port checks for the output configuration bank.
// Assumes it is bound to aoc_top and shares its clock and reset.
`timescale 1ns/1ps
module aoc_checker (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid,
	input wire logic [2:0] clk_div_ratio,
	input wire logic smp_valid,
	input wire logic dat_valid,
	input wire logic lvds_reduced,
	input aoc_pkg::aoc_term_t term_sel,
	input wire logic drive_double,
	input wire logic [3:0] out_clk_phase,
	input wire logic [2:0] in_clk_phase,
	input aoc_pkg::aoc_span_t ref_span,
	input wire logic sample_strobe,
	input wire logic out_clk_strobe
);
	// ****************************************************************
	// Decodes
	// ****************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	wire w_fmt = ce && reg_wr && reg_addr == 8'h14;
	wire w_drv = ce && reg_wr && reg_addr == 8'h15;
	wire w_ph = ce && reg_wr && reg_addr == 8'h16;
	wire w_ref = ce && reg_wr && reg_addr == 8'h18;
	wire r_hole = ce && reg_rd &&
		!(reg_addr inside {8'h10, 8'h14, 8'h15, 8'h16, 8'h18});
	// ****************************************************************
	// Assertions
	// ****************************************************************
	lvds_write_a: assert property (w_fmt |=>
		lvds_reduced == $past(reg_wdata[6])) else $error("lvds select");
	drive_write_a: assert property (w_drv |=>
		drive_double == $past(reg_wdata[0])) else $error("drive strength");
	term_map_a: assert property (w_drv ##1 ce |=> term_sel ==
		($past(reg_wdata[5:4], 2) == 2'h0 ? 2'h0 :
		$past(reg_wdata[5:4], 2) == 2'h1 ? 2'h1 : 2'h2))
		else $error("termination decode");
	phase_write_a: assert property (w_ph && reg_wdata[3:0] <= 4'hB |=>
		out_clk_phase == $past(reg_wdata[3:0])) else $error("out phase");
	ref_hold_a: assert property (w_ref && reg_wdata[2:0] > 3'h4 |=>
		$stable(ref_span)) else $error("reserved span taken");
	hole_zero_a: assert property (r_hole |=>
		reg_rvalid && reg_rdata == 8'h00) else $error("unmapped read");
	sample_period_a: assert property (sample_strobe && clk_div_ratio ==
		3'h2 |=> (!sample_strobe) [*2] ##1 sample_strobe)
		else $error("sample period");
	out_phase_a: assert property (sample_strobe && clk_div_ratio == 3'h2
		&& in_clk_phase == 3'h2 |=> ##1 out_clk_strobe)
		else $error("out clock phase");
	sample_out_a: assert property (ce && smp_valid |=> dat_valid)
		else $error("sample answer");
endmodule
bind aoc_top aoc_checker chk (.clk(clk), .sys_rst(sys_rst), .ce(ce),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
	.clk_div_ratio(clk_div_ratio), .smp_valid(smp_valid),
	.dat_valid(dat_valid), .lvds_reduced(lvds_reduced),
	.term_sel(term_sel), .drive_double(drive_double),
	.out_clk_phase(out_clk_phase), .in_clk_phase(in_clk_phase),
	.ref_span(ref_span), .sample_strobe(sample_strobe),
	.out_clk_strobe(out_clk_strobe));

// [test/aoc_host.sv]
// Serial port host model: byte writes and reads on the register port.
// Assumes requests change at the falling edge of clk.
`timescale 1ns/1ps
module aoc_host (
	input wire logic clk,
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic [1:0] chan_index,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid
);
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		chan_index = 2'b11;
	end
	task automatic wr(input logic [7:0] a, d, input logic [1:0] c);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		chan_index = c;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [1:0] c,
		output logic [7:0] d, output logic ok);
		ok = 1'b0;
		@(negedge clk);
		reg_addr = a;
		chan_index = c;
		reg_rd = 1'b1;
		for (int i = 0; i < 4 && !ok; i++) begin
			@(negedge clk);
			reg_rd = 1'b0;
			ok = (reg_rvalid === 1'b1);
		end
		d = reg_rdata;
	endtask
endmodule

// [test/aoc_top_tb_top.sv]
// Self-checking bench for the output configuration bank.
// Assumes the host model drives the register port.
`timescale 1ns/1ps
`define CHK(n, e, a) begin n_checks++; if ((a) !== (e)) begin \
	mismatches++; $display("[ERR] %s exp %h got %h", n, e, a); end end
module aoc_top_tb_top;
	logic clk, sys_rst, ce, reg_wr, reg_rd, reg_rvalid, smp_valid;
	logic dat_valid, lvds_reduced, drive_double, sample_strobe;
	logic out_clk_strobe;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic [1:0] chan_index;
	logic [2:0] clk_div_ratio, in_clk_phase;
	logic [11:0] smp_a_in, smp_b_in, dat_a_out, dat_b_out;
	logic [3:0] out_clk_phase;
	aoc_pkg::aoc_term_t term_sel;
	aoc_pkg::aoc_span_t ref_span;
	int mismatches = 0;
	int n_checks = 0;
	aoc_top uut (.clk(clk), .sys_rst(sys_rst), .ce(ce), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.chan_index(chan_index), .clk_div_ratio(clk_div_ratio),
		.smp_valid(smp_valid), .smp_a_in(smp_a_in), .smp_b_in(smp_b_in),
		.dat_a_out(dat_a_out), .dat_b_out(dat_b_out),
		.dat_valid(dat_valid), .lvds_reduced(lvds_reduced),
		.term_sel(term_sel), .drive_double(drive_double),
		.out_clk_phase(out_clk_phase), .in_clk_phase(in_clk_phase),
		.ref_span(ref_span), .sample_strobe(sample_strobe),
		.out_clk_strobe(out_clk_strobe));
	aoc_host host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.chan_index(chan_index), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid));
	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task summarize;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [1:0] c,
		input logic [7:0] e, input string n);
		logic [7:0] d;
		logic ok;
		host.rd(a, c, d, ok);
		`CHK("rvalid", 1'b1, ok)
		if (!ok)
			summarize();
		else
			`CHK(n, e, d)
	endtask
	task automatic smp(input logic [11:0] a, b);
		@(negedge clk);
		smp_a_in = a;
		smp_b_in = b;
		smp_valid = 1'b1;
		@(negedge clk);
		smp_valid = 1'b0;
		`CHK("dat_valid", 1'b1, dat_valid)
	endtask
	task automatic count(output int ns, no);
		ns = 0;
		no = 0;
		repeat (12) begin
			@(negedge clk);
			ns += sample_strobe;
			no += out_clk_strobe;
		end
	endtask
	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task t_reset;
		logic [7:0] a[5] = '{8'h10, 8'h14, 8'h15, 8'h16, 8'h18};
		logic [7:0] e[5] = '{8'h00, 8'h01, 8'h00, 8'h03, 8'h04};
		for (int i = 0; i < 5; i++)
			rdc(a[i], 2'b01, e[i], "reset");
		`CHK("term", 2'h0, term_sel)
		`CHK("span", 3'h4, ref_span)
		$display("t_reset done");
	endtask
	task t_fmt;
		host.wr(8'h14, 8'hFF, 2'b11);
		`CHK("lvds", 1'b1, lvds_reduced)
		rdc(8'h14, 2'b01, 8'h45, "fmt");
		host.wr(8'h14, 8'h00, 2'b11);
		`CHK("lvds", 1'b0, lvds_reduced)
		$display("t_fmt done");
	endtask
	task t_drv;
		logic [1:0] te[4] = '{2'h0, 2'h1, 2'h2, 2'h2};
		for (int c = 0; c < 4; c++) begin
			host.wr(8'h15, {2'b11, 2'(c), 4'hF}, 2'b11);
			@(negedge clk);
			`CHK("term", te[c], term_sel)
			`CHK("drive", 1'b1, drive_double)
			rdc(8'h15, 2'b01, {2'b00, 2'(c), 4'h1}, "drv");
		end
		host.wr(8'h15, 8'h00, 2'b11);
		`CHK("drive", 1'b0, drive_double)
		$display("t_drv done");
	endtask
	task t_phase;
		host.wr(8'h16, 8'h0B, 2'b11);
		`CHK("out phase", 4'hB, out_clk_phase)
		host.wr(8'h16, 8'hAC, 2'b11);
		`CHK("out phase", 4'hB, out_clk_phase)
		`CHK("in phase", 3'h2, in_clk_phase)
		rdc(8'h16, 2'b01, 8'h2B, "phase");
		$display("t_phase done");
	endtask
	task t_ref;
		for (int c = 0; c < 5; c++) begin
			host.wr(8'h18, {5'h1F, 3'(c)}, 2'b11);
			`CHK("span", 3'(c), ref_span)
		end
		host.wr(8'h18, 8'h05, 2'b11);
		`CHK("span", 3'h4, ref_span)
		rdc(8'h18, 2'b01, 8'h04, "ref");
		$display("t_ref done");
	endtask
	task t_trim;
		host.wr(8'h10, 8'h80, 2'b01);
		host.wr(8'h10, 8'h05, 2'b10);
		smp(12'h100, 12'h100);
		`CHK("dat a", 12'h080, dat_a_out)
		`CHK("dat b", 12'h105, dat_b_out)
		rdc(8'h10, 2'b10, 8'h05, "trim b");
		rdc(8'h10, 2'b01, 8'h80, "trim a");
		host.wr(8'h14, 8'h05, 2'b10);
		smp(12'h000, 12'h000);
		`CHK("dat a", 12'h800, dat_a_out)
		`CHK("dat b", 12'h7FA, dat_b_out)
		smp(12'hFFF, 12'hFFE);
		`CHK("dat a", 12'h77F, dat_a_out)
		`CHK("dat b", 12'h800, dat_b_out)
		$display("t_trim done");
	endtask
	task t_hole;
		host.wr(8'h11, 8'hFF, 2'b11);
		rdc(8'h11, 2'b01, 8'h00, "hole");
		@(negedge clk);
		ce = 1'b0;
		host.wr(8'h18, 8'h00, 2'b11);
		ce = 1'b1;
		`CHK("span", 3'h4, ref_span)
		$display("t_hole done");
	endtask
	task t_clk;
		int ns, no;
		@(negedge clk);
		clk_div_ratio = 3'h2;
		repeat (3) @(negedge clk);
		count(ns, no);
		`CHK("samples", 4, ns)
		`CHK("out clocks", 4, no)
		host.wr(8'h16, 8'h0B, 2'b11);
		count(ns, no);
		`CHK("samples", 4, ns)
		`CHK("out clocks", 4, no)
		$display("t_clk done");
	endtask
	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		clk = 0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		sys_rst = 1'b1;
		ce = 1'b1;
		clk_div_ratio = 3'h0;
		smp_valid = 1'b0;
		smp_a_in = 12'h000;
		smp_b_in = 12'h000;
		repeat (20) @(negedge clk);
		sys_rst = 1'b0;
		t_reset();
		t_fmt();
		t_drv();
		t_phase();
		t_ref();
		t_trim();
		t_hole();
		t_clk();
		summarize();
	end
endmodule
